/* File: design/slau_defs.svh */
// Constants for the store lane address unit
`ifndef SLAU_DEFS_SVH
`define SLAU_DEFS_SVH
`define SLAU_DATA_W        32
`define SLAU_PFX_W         11
`define SLAU_REG_IDX_W     5
`define SLAU_WORD_SCALE_SH 2
`define SLAU_HALF_SCALE_SH 1
`define SLAU_OP_WORD       16'h7E40
`define SLAU_OP_WORD_MASK  16'hFFE0
`define SLAU_OP_HALF_PTR   16'h7E20
`define SLAU_OP_HALF_MASK  16'hFFE0
`define SLAU_OP_HALF_FIX   16'h7B40
`define SLAU_OP_HFIX_MASK  16'hFFC0
`define SLAU_OP_BYTE_PTR   16'h7A00
`define SLAU_OP_BYTE_MASK  16'hFFE0
`define SLAU_HFIX_IMM_BIT  5
`define SLAU_BE_NONE       4'h0
`define SLAU_BE_ALL        4'hF
`define SLAU_BE_LO_HALF    4'h3
`define SLAU_BE_HI_HALF    4'hC
`endif

/* File: design/slau_pkg.sv */
// Types for the store lane address unit
`default_nettype none
package slau_pkg;
    typedef enum logic [2:0] {
        SLAU_NONE,
        SLAU_WORD,
        SLAU_HALF_PTR,
        SLAU_HALF_FIX,
        SLAU_BYTE_PTR
    } slau_op_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
    } slau_wr_t;
endpackage
`default_nettype wire

/* File: design/slau_store_unit.sv */
// Store instruction decoder, address former and lane selector
// Operation
// - Word store at pointer with low bits dropped
// - Prefixed word store adds sign-extended prefix times four
// - Half store by pointer, bit 1 picks lane
// - Prefixed pointer stores add prefix times four
// - Half-by-pointer opcode pattern bits fifteen to five
// - Fixed-lane half store adds twice the immediate
// - Half lane one is upper half
// - Prefixed fixed-lane offset is prefix:immediate doubled
// - Fixed-lane opcode holds immediate and register index
// - Byte store by pointer, low bits pick byte
// - Byte lane three is most significant byte
// - Prefix register loaded by prefix, used next
`timescale 1ns/1ps
`default_nettype none
`include "slau_defs.svh"
module slau_store_unit
    import slau_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        prefix_load,
    input  wire logic [10:0] prefix_value,
    input  wire logic [31:0] first_source_reg,
    input  wire logic [31:0] base_pointer_reg,
    input  wire logic [31:0] lane_source_reg_zero,
    input  wire logic [3:0]  flags_in,
    output logic [4:0]       reg_index,
    output logic             store_hit,
    output logic [3:0]       flags_out,
    output var slau_wr_t     mem_wr
);
    logic [10:0] prefix_value_reg_q;
    logic [10:0] prefix_value_reg_d;
    logic        prefix_pending_q;
    logic        prefix_pending_d;
    slau_wr_t    mem_wr_q;
    slau_wr_t    mem_wr_d;
    slau_op_t    op;
    logic [31:0] pfx_word_off;
    logic [31:0] hfix_off;
    logic [31:0] ptr_addr;
    logic [11:0] hfix_k;
    logic        half_lane_select_bit;
    logic [31:0] store_data;
    logic [3:0]  store_be;

    logic        match_word;
    logic        match_half_ptr;
    logic        match_half_fix;
    logic        match_byte_ptr;

    logic [31:0] word_addr;
    logic [31:0] half_ptr_addr;
    logic [31:0] half_fix_addr;
    logic [31:0] byte_addr;
    logic [3:0]  half_ptr_be;
    logic [3:0]  half_fix_be;
    logic [3:0]  byte_be;

    // Opcode matches; the four patterns are disjoint under their masks
    assign match_half_ptr = ((instr_word & `SLAU_OP_HALF_MASK) == `SLAU_OP_HALF_PTR);
    assign match_byte_ptr = ((instr_word & `SLAU_OP_BYTE_MASK) == `SLAU_OP_BYTE_PTR);
    assign match_half_fix = ((instr_word & `SLAU_OP_HFIX_MASK) == `SLAU_OP_HALF_FIX);
    assign match_word     = ((instr_word & `SLAU_OP_WORD_MASK) == `SLAU_OP_WORD);

    // Decode
    always_comb begin
        op = SLAU_NONE;
        if (instr_valid) begin
            if (match_half_ptr) begin
                op = SLAU_HALF_PTR;
            end else if (match_byte_ptr) begin
                op = SLAU_BYTE_PTR;
            end else if (match_half_fix) begin
                op = SLAU_HALF_FIX;
            end else if (match_word) begin
                op = SLAU_WORD;
            end
        end
    end

    assign reg_index = instr_word[4:0];
    assign store_hit = (op != SLAU_NONE);
    assign flags_out = flags_in;
    assign mem_wr    = mem_wr_q;
    assign half_lane_select_bit      = instr_word[`SLAU_HFIX_IMM_BIT];

    // Prefix offsets, word scaled or half scaled
    always_comb begin
        pfx_word_off = {{19{prefix_value_reg_q[10]}}, prefix_value_reg_q, 2'b00};
        hfix_k       = prefix_pending_q ? {prefix_value_reg_q, half_lane_select_bit} : {11'h000, half_lane_select_bit};
        hfix_off     = prefix_pending_q ? {{19{hfix_k[11]}}, hfix_k, 1'b0}
                                        : {30'h0, half_lane_select_bit, 1'b0};
        ptr_addr     = prefix_pending_q ? first_source_reg + pfx_word_off
                                        : first_source_reg;
    end

    // Effective address and lane enables per store kind
    // A word-scaled prefix keeps the pointer's low bits, so lanes still follow them
    always_comb begin
        word_addr      = prefix_pending_q ? base_pointer_reg + pfx_word_off
                                          : base_pointer_reg;
        word_addr[1:0] = 2'b00;
        half_ptr_addr  = {ptr_addr[31:1], 1'b0};
        half_fix_addr  = {first_source_reg[31:2], 2'b00} + hfix_off;
        byte_addr      = ptr_addr;
        half_ptr_be    = ptr_addr[1] ? `SLAU_BE_HI_HALF
                                     : `SLAU_BE_LO_HALF;
        half_fix_be    = half_lane_select_bit ? `SLAU_BE_HI_HALF
                              : `SLAU_BE_LO_HALF;
        byte_be        = 4'(4'h1 << ptr_addr[1:0]);
    end

    // Store data: the full operand, the byte enables pick the lanes
    always_comb begin
        case (op)
            SLAU_WORD: begin
                store_data = first_source_reg;
            end
            default: begin
                store_data = lane_source_reg_zero;
            end
        endcase
    end

    // Byte enables: all lanes for a word, only the chosen lanes otherwise
    always_comb begin
        case (op)
            SLAU_WORD: begin
                store_be = `SLAU_BE_ALL;
            end
            SLAU_HALF_PTR: begin
                store_be = half_ptr_be;
            end
            SLAU_HALF_FIX: begin
                store_be = half_fix_be;
            end
            SLAU_BYTE_PTR: begin
                store_be = byte_be;
            end
            default: begin
                store_be = `SLAU_BE_NONE;
            end
        endcase
    end

    // Prefix value: loaded by a prefix, held until the next one
    always_comb begin
        prefix_value_reg_d = prefix_value_reg_q;
        if (prefix_load) begin
            prefix_value_reg_d = prefix_value;
        end
    end

    // Prefix pending: set by a prefix, consumed by the next instruction
    // A prefix arriving with an instruction stays pending for the one after
    always_comb begin
        prefix_pending_d = prefix_pending_q;
        if (prefix_load) begin
            prefix_pending_d = 1'b1;
        end else if (instr_valid) begin
            prefix_pending_d = 1'b0;
        end
    end

    // Write request formation
    always_comb begin
        mem_wr_d       = '0;
        mem_wr_d.valid = 1'b0;
        mem_wr_d.be    = `SLAU_BE_NONE;
        case (op)
            SLAU_WORD: begin
                mem_wr_d.valid = 1'b1;
                mem_wr_d.addr  = word_addr;
                mem_wr_d.data  = store_data;
                mem_wr_d.be    = store_be;
            end
            SLAU_HALF_PTR: begin
                mem_wr_d.valid = 1'b1;
                mem_wr_d.addr  = half_ptr_addr;
                mem_wr_d.data  = store_data;
                mem_wr_d.be    = store_be;
            end
            SLAU_HALF_FIX: begin
                mem_wr_d.valid = 1'b1;
                mem_wr_d.addr  = half_fix_addr;
                mem_wr_d.data  = store_data;
                mem_wr_d.be    = store_be;
            end
            SLAU_BYTE_PTR: begin
                mem_wr_d.valid = 1'b1;
                mem_wr_d.addr  = byte_addr;
                mem_wr_d.data  = store_data;
                mem_wr_d.be    = store_be;
            end
            default: begin
                mem_wr_d.valid = 1'b0;
            end
        endcase
    end

    // Prefix value register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prefix_value_reg_q <= 11'h000;
        end else begin
            prefix_value_reg_q <= prefix_value_reg_d;
        end
    end

    // Prefix pending register; reset drops any prefix in flight
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prefix_pending_q <= 1'b0;
        end else begin
            prefix_pending_q <= prefix_pending_d;
        end
    end

    // Write request register; the request stands for one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_q <= '0;
        end else begin
            mem_wr_q <= mem_wr_d;
        end
    end
endmodule
`default_nettype wire

/* File: tb/slau_mem_model.sv */
// Data memory behind the store unit, applies byte enables
`timescale 1ns/1ps
`default_nettype none
module slau_mem_model import slau_pkg::*; (
    input wire logic     mclk,
    input wire slau_wr_t wr
);
    logic [31:0] mem [16];
    initial foreach (mem[i]) mem[i] = 32'h5AC3_0000 + 32'(i);
    always @(posedge mclk)
        if (wr.valid)
            for (int j = 0; j < 4; j++)
                if (wr.be[j]) mem[wr.addr[5:2]][8*j+:8] <= wr.data[8*j+:8];
endmodule
`default_nettype wire

/* File: tb/slau_store_checker.sv */
// Concurrent checks on the store unit ports
`timescale 1ns/1ps
`default_nettype none
module slau_store_checker import slau_pkg::*; (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic        prefix_load,
    input wire logic [10:0] prefix_value,
    input wire logic [31:0] first_source_reg,
    input wire logic [3:0]  flags_in,
    input wire logic [3:0]  flags_out,
    input wire slau_wr_t    mem_wr
);
    logic        pend_q;
    logic [10:0] k_q;
    wire logic is_w = instr_valid && instr_word[15:5] == 11'h3F2;
    wire logic is_h = instr_valid && instr_word[15:5] == 11'h3F1;
    wire logic is_b = instr_valid && instr_word[15:5] == 11'h3D0;
    wire logic is_f = instr_valid && instr_word[15:6] == 10'h1ED;
    wire logic [31:0] pa = first_source_reg + {{19{k_q[10]}}, k_q, 2'h0};
    wire logic [31:0] fa = {first_source_reg[31:2], instr_word[5], 1'h0};
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n) {pend_q, k_q} <= '0;
        else if (prefix_load) {pend_q, k_q} <= {1'h1, prefix_value};
        else if (instr_valid) pend_q <= 1'h0;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    flags_same_a:
        assert property (flags_out == flags_in) else $error("flags changed");
    word_store_a:
        assert property (is_w |=> mem_wr.valid && mem_wr.be == 4'hF && mem_wr.addr[1:0] == 2'h0
            && mem_wr.data == $past(first_source_reg)) else $error("bad word store");
    half_lane_a:
        assert property (is_h |=> mem_wr.be == ($past(first_source_reg[1]) ? 4'hC : 4'h3))
            else $error("bad half lane");
    byte_lane_a:
        assert property (is_b |=> mem_wr.be == 4'h1 << $past(first_source_reg[1:0]))
            else $error("bad byte lane");
    fix_lane_a:
        assert property (is_f |=> mem_wr.be == ($past(instr_word[5]) ? 4'hC : 4'h3))
            else $error("bad fixed lane");
    pfx_byte_a:
        assert property (is_b && pend_q |=> mem_wr.addr == $past(pa)) else $error("bad offset");
    fix_addr_a:
        assert property (is_f && !pend_q |=> mem_wr.addr == $past(fa)) else $error("bad address");
    quiet_bus_a:
        assert property (!(is_w || is_h || is_b || is_f) |=> !mem_wr.valid) else $error("stray write");
    cover property (is_b && pend_q);
    cover property (is_f && pend_q);
    cover property (is_w ##1 is_h);
endmodule
bind slau_store_unit slau_store_checker u_chk (.mclk, .rst_n, .instr_valid, .instr_word,
    .prefix_load, .prefix_value, .first_source_reg, .flags_in, .flags_out, .mem_wr);
`default_nettype wire

/* File: tb/tb_store_lane_address_unit.sv */
// Random and corner stimulus for the store unit
`timescale 1ns/1ps
`default_nettype none
module tb_store_lane_address_unit;
    import slau_pkg::*;
    logic        mclk, rst_n, instr_valid, prefix_load, i, store_hit, crn;
    logic [4:0]  reg_index;
    logic [15:0] instr_word;
    logic [10:0] prefix_value, k;
    logic [31:0] ra, rb, r0, old, ad, m;
    logic [3:0]  flags_in, flags_out;
    slau_wr_t    mem_wr, exp;
    int          seed = 62, err_total = 0, cmp_count = 0;
    slau_store_unit u_dut (.mclk, .rst_n, .instr_valid, .instr_word, .prefix_load, .prefix_value,
        .first_source_reg(ra), .base_pointer_reg(rb), .lane_source_reg_zero(r0), .flags_in,
        .reg_index, .store_hit, .flags_out, .mem_wr);
    slau_mem_model u_mem (.mclk, .wr(mem_wr));
    task automatic chk(input logic [68:0] g, input logic [68:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic run(input int op, input logic pf);
        {ra, rb, r0, flags_in} = {$random(seed), $random(seed), $random(seed), 4'($random(seed))};
        i = ra[7];
        prefix_load = pf;
        prefix_value = crn ? 11'h400 : 11'($random(seed));
        @(negedge mclk);
        prefix_load = 1'h0;
        k = pf ? prefix_value : 11'h0;
        instr_word = {op == 0 ? 11'h3F2 : op == 1 ? 11'h3F1 : op == 3 ? 11'h3D0 :
            op == 2 ? {10'h1ED, i} : 11'h0, ra[12:8]};
        ad = op == 0 ? (rb + {{19{k[10]}}, k, 2'h0}) & ~32'h3 : op == 2 ?
            {ra[31:2], 2'h0} + {{19{k[10]}}, k, i, 1'h0} : ra + {{19{k[10]}}, k, 2'h0};
        exp = '{1'h1, op == 1 ? {ad[31:1], 1'h0} : ad, op == 0 ? ra : r0,
            op == 0 ? 4'hF : op == 3 ? 4'h1 << ad[1:0] : ad[1] ? 4'hC : 4'h3};
        m = {{8{exp.be[3]}}, {8{exp.be[2]}}, {8{exp.be[1]}}, {8{exp.be[0]}}};
        old = u_mem.mem[exp.addr[5:2]];
        instr_valid = 1'h1;
        #1;
        chk(69'({store_hit, reg_index}), 69'({op != 4, ra[12:8]}));
        chk(69'(flags_out), 69'(flags_in));
        @(negedge mclk);
        instr_valid = 1'h0;
        if (op == 4) chk(69'(mem_wr.valid), 69'h0);
        else chk(mem_wr, exp);
        @(negedge mclk);
        if (op != 4) chk(69'(u_mem.mem[exp.addr[5:2]]), 69'((old & ~m) | (exp.data & m)));
    endtask
    task automatic summarize;
        $display("Compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #50us;
        err_total++;
        summarize;
    end
    initial begin
        {rst_n, instr_valid, prefix_load, instr_word, prefix_value, ra, rb, r0, flags_in} = '0;
        crn = 1'h0;
        repeat (10) @(negedge mclk);
        rst_n = 1'h1;
        for (int op = 0; op < 5; op++) begin
            run(op, 1'h0);
            run(op, 1'h1);
        end
        crn = 1'h1;
        for (int op = 0; op < 4; op++) begin
            run(op, 1'h1);
        end
        crn = 1'h0;
        prefix_load  = 1'h1;
        prefix_value = 11'h7FF;
        @(negedge mclk);
        prefix_load = 1'h0;
        rst_n       = 1'h0;
        @(negedge mclk);
        rst_n = 1'h1;
        run(0, 1'h0);
        repeat (200) run($unsigned($random(seed)) % 5, 1'($random(seed)));
        summarize;
    end
endmodule
`default_nettype wire
